// >>> dv/core_model.sv
`timescale 1ns/1ns

module core_model
(
    input  wire         ref_clk_i,
    input  wire         rst_n_i,
    input  wire [1:0]   qphase_i,
    input  wire         pc_load_i,
    input  wire [12:0]  vector_pc_i,
    output logic [12:0] pc_o
);
    // One instruction per Tcy; only the PC is handed over at entry
    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pc_o <= 13'h0100;
        else if (pc_load_i)
            pc_o <= vector_pc_i;
        else if (qphase_i == 2'h3)
            pc_o <= pc_o + 13'h0001;
    end
endmodule // core_model

// >>> dv/irq_ctrl_assertions.sv
`timescale 1ns/1ns
`include "irq_ctrl_map.vh"

module irq_ctrl_checker
(
    input wire               ref_clk_i,
    input wire               rst_n_i,
    input wire               warm_reset_i,
    input wire [`ADDR_W-1:0] avs_address_i,
    input wire               avs_read_i,
    input wire               avs_write_i,
    input wire [31:0]        avs_writedata_i,
    input wire [3:0]         avs_byteenable_i,
    input wire [31:0]        avs_readdata_o,
    input wire               avs_waitrequest_o,
    input wire               sleep_i,
    input wire [`PC_W-1:0]   pc_i,
    input wire               wake_o,
    input wire               irq_take_o,
    input wire               stack_push_o,
    input wire [`PC_W-1:0]   return_pc_o,
    input wire               pc_load_o,
    input wire [`PC_W-1:0]   vector_pc_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire bus_done = !avs_waitrequest_o;

    property p_take_pair; irq_take_o |-> stack_push_o && pc_load_o; endproperty
    a_take_pair: assert property (p_take_pair) else $error("take without push and load");
    property p_vector; pc_load_o |-> vector_pc_o == 13'h0004; endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");
    property p_ret_pc; irq_take_o |-> return_pc_o == $past(pc_i); endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return pc not captured");
    // Global enable is gone after a take, so no second take follows at once
    property p_take_gap; irq_take_o |=> !irq_take_o [*8]; endproperty
    a_take_gap: assert property (p_take_gap) else $error("take repeated");
    property p_wake; !sleep_i |-> !wake_o; endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_pflag_read;
        avs_read_i && bus_done && (avs_address_i == 12'h030 || avs_address_i == 12'h230)
        |-> (avs_readdata_o & 32'hFFFF_FF36) == 32'h0000_0000;
    endproperty
    a_pflag_read: assert property (p_pflag_read) else $error("unused peripheral bit set");
    property p_warm_quiet; warm_reset_i |=> !irq_take_o [*8]; endproperty
    a_warm_quiet: assert property (p_warm_quiet) else $error("take after reset");
    property p_gie_off;
        avs_write_i && bus_done && avs_address_i == 12'h02C && avs_byteenable_i[0] && !avs_writedata_i[7]
        |=> ##1 !irq_take_o [*7];
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("take with global enable clear");

    c_take: cover property (irq_take_o);
    c_wake: cover property (wake_o);
    c_pflag_read: cover property (avs_read_i && bus_done && avs_address_i == 12'h030);
endmodule // irq_ctrl_checker

bind mcu_interrupt_controller irq_ctrl_checker chk_u (.*);

// >>> dv/testbench.sv
`timescale 1ns/1ns

module testbench;
    logic        ref_clk_i;
    logic        rst_n_i;
    logic [11:0] avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [7:0]  ev;
    logic        pin;
    logic [5:0]  port;
    logic        sleep;
    logic        prd;
    logic [7:0]  q;
    logic [7:0]  d;
    logic [12:0] pc_prev;
    wire  [31:0] rdata;
    wire         wreq;
    wire         wake;
    wire         take;
    wire         load;
    wire  [12:0] rpc;
    wire  [12:0] vpc;
    wire  [12:0] pc;
    wire  [1:0]  qph;
    int          fail_count;
    int          n_tests;
    int          n;
    logic [11:0] ra [7] = '{12'h02C, 12'h030, 12'h230, 12'h204, 12'h258, 12'h238, 12'h3FC};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};

    // Testbench-driven prd stands in for core port reads that refresh the pin-change reference
    mcu_interrupt_controller dut_u
    (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .warm_reset_i(ev[6]), .brownout_reset_i(ev[7]),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .external_irq_pin_i(pin), .port_pins_i(port), .port_read_i(prd),
        .timer_zero_rollover_i(ev[0]), .comparator_change_i(ev[1]), .conversion_done_i(ev[2]),
        .timer_one_overflow_i(ev[3]), .nvm_write_done_i(ev[4]), .return_from_irq_instruction_i(ev[5]),
        .sleep_i(sleep), .pc_i(pc), .wake_o(wake), .irq_take_o(take), .stack_push_o(),
        .return_pc_o(rpc), .pc_load_o(load), .vector_pc_o(vpc), .qphase_o(qph)
    );
    core_model core_u
    (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .qphase_i(qph), .pc_load_i(load),
        .vector_pc_i(vpc), .pc_o(pc)
    );

    function logic [7:0] ev_bit(input int i);
        return (i == 0) ? 8'h04 : (i == 1) ? 8'h08 : (i == 2) ? 8'h40 : (i == 3) ? 8'h01 : 8'h80;
    endfunction

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge; data taken there
    task bus(input logic w, input logic [11:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h00_0000, v};
        avs_write_i <= w;
        avs_read_i <= !w;
        @(posedge ref_clk_i);
        while (wreq !== 1'b0)
            @(posedge ref_clk_i);
        q = rdata[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask

    task rd(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask

    task pulse(input int i);
        @(posedge ref_clk_i);
        ev[i] <= 1'b1;
        @(posedge ref_clk_i);
        ev[i] <= 1'b0;
    endtask

    task wait_take;
        n = 0;
        while (take !== 1'b1 && n < 40)
        begin
            pc_prev = pc;
            @(negedge ref_clk_i);
            n++;
        end
    endtask

    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        conclude();
    end

    initial
    begin
        fail_count = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        avs_address_i = 12'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0000_0000;
        ev = 8'h00;
        pin = 1'b0;
        port = 6'h00;
        sleep = 1'b0;
        prd = 1'b0;
        n = $urandom(32'h0ed7);
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(ra[i], rv[i]);
        repeat (4)
        begin
            d = $urandom;
            wr(12'h030, d);
            rd(12'h030, d & 8'hC9);
            wr(12'h230, ~d);
            rd(12'h230, ~d & 8'hC9);
        end
        wr(12'h030, 8'h00);
        wr(12'h230, 8'h00);
        $display("registers done");
        sleep <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            pulse(i);
            rd(i ? 12'h030 : 12'h02C, ev_bit(i));
            chk(wake, 1'b0);
            wr(i ? 12'h030 : 12'h02C, 8'h00);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(12'h204, i ? 8'hBF : 8'hFF);
            wr(12'h02C, 8'h10);
            pin <= 1'b1;
            repeat (8) @(posedge ref_clk_i);
            chk(wake, !i);
            rd(12'h02C, i ? 8'h10 : 8'h12);
            wr(12'h02C, 8'h10);
            pin <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
            rd(12'h02C, i ? 8'h12 : 8'h10);
        end
        sleep <= 1'b0;
        $display("flags done");
        wr(12'h02C, 8'hA0);
        pulse(0);
        wait_take();
        chk(n >= 10 && n <= 13, 1'b1);
        chk(rpc, pc_prev);
        @(negedge ref_clk_i);
        chk(pc, 13'h0004);
        rd(12'h02C, 8'h24);
        wr(12'h02C, 8'h20);
        pulse(5);
        rd(12'h02C, 8'hA0);
        wr(12'h02C, 8'h20);
        pulse(0);
        wait_take();
        chk(n, 40);
        wr(12'h02C, 8'hA4);
        wait_take();
        chk(n <= 13, 1'b1);
        wr(12'h230, 8'h40);
        wr(12'h02C, 8'h80);
        pulse(2);
        wait_take();
        chk(n, 40);
        wr(12'h02C, 8'hC0);
        wait_take();
        chk(n <= 13, 1'b1);
        wr(12'h230, 8'h00);
        wr(12'h02C, 8'h00);
        $display("service done");
        wr(12'h258, 8'h01);
        port <= 6'h02;
        repeat (8) @(posedge ref_clk_i);
        rd(12'h02C, 8'h00);
        port <= 6'h03;
        repeat (8) @(posedge ref_clk_i);
        rd(12'h02C, 8'h01);
        prd <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        prd <= 1'b0;
        wr(12'h02C, 8'h00);
        repeat (8) @(posedge ref_clk_i);
        rd(12'h02C, 8'h00);
        wr(12'h02C, 8'h79);
        wr(12'h238, 8'h01);
        pulse(6);
        rd(12'h02C, 8'h01);
        rd(12'h238, 8'h01);
        pulse(7);
        rd(12'h238, 8'h00);
        $display("resets done");
        conclude();
    end
endmodule // testbench

// >>> rtl/irq_ctrl_map.vh
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// Register indexes; byte address is four times the index
`define IDX_INTCTL          10'h00B
`define IDX_PFLAGS          10'h00C
`define IDX_OPTION          10'h081
`define IDX_PENABLES        10'h08C
`define IDX_PWRCTL          10'h08E
`define IDX_PINMASK         10'h096
`define ADDR_W              12

// Control/status field positions
`define B_GLOBAL_EN         7
`define B_PERIPH_EN         6
`define B_T0_EN             5
`define B_EXT_EN            4
`define B_PORT_EN           3
`define B_T0_FLAG           2
`define B_EXT_FLAG          1
`define B_PORT_FLAG         0

// Peripheral flag/enable field positions
`define B_NVM               7
`define B_CONV              6
`define B_CMP               3
`define B_T1                0
`define PERIPH_MASK         8'hC9

// Option register field and power-control field
`define B_EDGE_SEL          6
`define B_BOR_FLAG          0

// Reset values
`define RST_INTCTL          8'h00
`define RST_PFLAGS          8'h00
`define RST_PENABLES        8'h00
`define RST_OPTION          8'hFF
`define RST_PINMASK         6'h00
`define RST_PWRCTL          1'b0

// Vector and timing
`define IRQ_VECTOR          13'h0004
`define PC_W                13
`define QPHASES             4
`define CLK_PERIOD_NS       10
`define TCY_NS              (`QPHASES * `CLK_PERIOD_NS)
`define SYNC_LATENCY_TCY    3
`define TAKE_DELAY_TCY      (`SYNC_LATENCY_TCY - 1)

`endif

// >>> rtl/mcu_interrupt_controller.v
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "irq_ctrl_map.vh"

module mcu_interrupt_controller
(
    input  wire              ref_clk_i,
    input  wire              rst_n_i,
    input  wire              warm_reset_i,
    input  wire              brownout_reset_i,
    input  wire [`ADDR_W-1:0] avs_address_i,
    input  wire              avs_read_i,
    input  wire              avs_write_i,
    input  wire [31:0]       avs_writedata_i,
    input  wire [3:0]        avs_byteenable_i,
    output wire [31:0]       avs_readdata_o,
    output wire              avs_waitrequest_o,
    input  wire              external_irq_pin_i,
    input  wire [5:0]        port_pins_i,
    input  wire              port_read_i,
    input  wire              timer_zero_rollover_i,
    input  wire              comparator_change_i,
    input  wire              conversion_done_i,
    input  wire              timer_one_overflow_i,
    input  wire              nvm_write_done_i,
    input  wire              return_from_irq_instruction_i,
    input  wire              sleep_i,
    input  wire [`PC_W-1:0]  pc_i,
    output wire              wake_o,
    output reg               irq_take_o,
    output reg               stack_push_o,
    output reg  [`PC_W-1:0]  return_pc_o,
    output reg               pc_load_o,
    output reg  [`PC_W-1:0]  vector_pc_o,
    output wire [1:0]        qphase_o
);

    reg  [7:0]  intctl_r;
    reg  [7:0]  intctl_nxt;
    reg  [7:0]  pflags_r;
    reg  [7:0]  pflags_nxt;
    reg  [7:0]  penables_r;
    reg  [7:0]  option_r;
    reg  [5:0]  pinmask_r;
    reg         pwrctl_r;
    reg  [1:0]  qphase_r;
    reg  [2:0]  ext_sync_r;
    reg  [2:0]  port_sync_r [0:5];
    reg  [5:0]  port_stable_r;
    reg  [5:0]  port_latch_r;
    reg         ext_stable_r;
    reg         ack_r;
    reg  [31:0] rdata_r;
    reg         sampled_r;
    reg  [1:0]  take_cnt_r;

    wire        q1_en;
    wire        q2_en;
    wire        bus_req;
    wire        wr_en;
    wire [9:0]  idx;
    wire [7:0]  wbyte;
    wire        ext_now;
    wire        ext_edge;
    wire [5:0]  port_now;
    wire        port_change;
    wire [7:0]  pev;
    wire        core_pending;
    wire        periph_pending;
    wire        pending;
    wire        wake_src;
    wire        port_read_q2;
    wire        ext_rise;
    wire        ext_fall;
    reg  [7:0]  rd_mux;

    // Countdown reload, cut to the counter width on purpose
    localparam [31:0] TAKE_RELOAD = `TAKE_DELAY_TCY;

    // Instruction cycle split in four quarter phases, one clock each
    assign q1_en    = (qphase_r == 2'd0);
    assign q2_en    = (qphase_r == 2'd1);
    assign qphase_o = qphase_r;

    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            qphase_r <= 2'd0;
        else
            qphase_r <= qphase_r + 2'd1;
    end

    // Avalon slave: one wait cycle, read data ready at the release edge
    assign bus_req           = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_r;
    assign avs_readdata_o    = rdata_r;
    assign idx               = avs_address_i[`ADDR_W-1:2];
    assign wr_en             = avs_write_i & ack_r & avs_byteenable_i[0];
    assign wbyte             = avs_writedata_i[7:0];

    always @*
    begin
        case (idx)
            `IDX_INTCTL:   rd_mux = intctl_r;
            `IDX_PFLAGS:   rd_mux = pflags_r & `PERIPH_MASK;
            `IDX_PENABLES: rd_mux = penables_r & `PERIPH_MASK;
            `IDX_OPTION:   rd_mux = option_r;
            `IDX_PINMASK:  rd_mux = {2'b00, pinmask_r};
            `IDX_PWRCTL:   rd_mux = {7'b000_0000, pwrctl_r};
            default:       rd_mux = 8'h00;
        endcase
    end

    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r   <= bus_req & ~ack_r;
            rdata_r <= {24'h00_0000, rd_mux};
        end
    end

    // Pin inputs: three flops, change accepted when stages two and three agree
    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ext_sync_r   <= 3'b000;
            ext_stable_r <= 1'b0;
        end
        else
        begin
            ext_sync_r <= {ext_sync_r[1:0], external_irq_pin_i};
            if (ext_sync_r[2] == ext_sync_r[1])
                ext_stable_r <= ext_sync_r[2];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : g_port
            always @(posedge ref_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    port_sync_r[g]   <= 3'b000;
                    port_stable_r[g] <= 1'b0;
                end
                else
                begin
                    port_sync_r[g] <= {port_sync_r[g][1:0], port_pins_i[g]};
                    if (port_sync_r[g][2] == port_sync_r[g][1])
                        port_stable_r[g] <= port_sync_r[g][2];
                end
            end
        end
    endgenerate

    assign ext_now  = ext_stable_r;
    assign port_now = port_stable_r;

    // Previous pin level kept from the stable stage, so no extra edge at start
    reg ext_prev_r;
    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ext_prev_r <= 1'b0;
        else
            ext_prev_r <= ext_now;
    end

    assign ext_rise = ext_now & ~ext_prev_r;
    assign ext_fall = ~ext_now & ext_prev_r;
    assign ext_edge = option_r[`B_EDGE_SEL] ? ext_rise : ext_fall;

    // Port reads refresh the reference; a change landing on that read is lost
    assign port_read_q2 = port_read_i & q2_en;

    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            port_latch_r <= 6'h00;
        else if (port_read_q2)
            port_latch_r <= port_now;
    end

    assign port_change = |((port_now ^ port_latch_r) & pinmask_r) & ~port_read_q2;

    assign pev = {nvm_write_done_i, conversion_done_i, 2'b00, comparator_change_i, 2'b00, timer_one_overflow_i};

    // Control/status next value: event sets win over software clears
    always @*
    begin
        intctl_nxt = intctl_r;
        if (wr_en && idx == `IDX_INTCTL)
            intctl_nxt = wbyte;
        if (return_from_irq_instruction_i)
            intctl_nxt[`B_GLOBAL_EN] = 1'b1;
        if (irq_take_o)
            intctl_nxt[`B_GLOBAL_EN] = 1'b0;
        if (ext_edge)
            intctl_nxt[`B_EXT_FLAG] = 1'b1;
        if (timer_zero_rollover_i)
            intctl_nxt[`B_T0_FLAG] = 1'b1;
        if (port_change)
            intctl_nxt[`B_PORT_FLAG] = 1'b1;
    end

    // Unimplemented peripheral positions never store, so they read as zero
    always @*
    begin
        pflags_nxt = pflags_r;
        if (wr_en && idx == `IDX_PFLAGS)
            pflags_nxt = wbyte & `PERIPH_MASK;
        pflags_nxt = pflags_nxt | pev;
    end

    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            intctl_r   <= `RST_INTCTL;
            pflags_r   <= `RST_PFLAGS;
            penables_r <= `RST_PENABLES;
            option_r   <= `RST_OPTION;
            pinmask_r  <= `RST_PINMASK;
        end
        // Pin mask cleared too, so the kept port flag is not raised again
        else if (warm_reset_i | brownout_reset_i)
        begin
            intctl_r   <= {7'b000_0000, intctl_r[`B_PORT_FLAG]};
            pflags_r   <= `RST_PFLAGS;
            penables_r <= `RST_PENABLES;
            option_r   <= `RST_OPTION;
            pinmask_r  <= `RST_PINMASK;
        end
        else
        begin
            intctl_r <= intctl_nxt;
            pflags_r <= pflags_nxt;
            if (wr_en && idx == `IDX_PENABLES)
                penables_r <= wbyte & `PERIPH_MASK;
            if (wr_en && idx == `IDX_OPTION)
                option_r <= wbyte;
            if (wr_en && idx == `IDX_PINMASK)
                pinmask_r <= wbyte[5:0];
        end
    end

    // Power-control bit survives warm reset; only brown-out, rst_n_i or a software write of zero clear it
    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pwrctl_r <= `RST_PWRCTL;
        else if (brownout_reset_i)
            pwrctl_r <= 1'b0;
        else if (wr_en && idx == `IDX_PWRCTL)
            pwrctl_r <= wbyte[`B_BOR_FLAG];
    end

    // Request terms; global enable only gates servicing, not wake-up
    assign core_pending = (intctl_r[`B_T0_EN] & intctl_r[`B_T0_FLAG]) |
                          (intctl_r[`B_EXT_EN] & intctl_r[`B_EXT_FLAG]) |
                          (intctl_r[`B_PORT_EN] & intctl_r[`B_PORT_FLAG]);
    assign periph_pending = intctl_r[`B_PERIPH_EN] & |(pflags_r & penables_r & `PERIPH_MASK);
    assign wake_src = core_pending | periph_pending;
    assign pending  = wake_src & intctl_r[`B_GLOBAL_EN];
    assign wake_o   = sleep_i & wake_src;

    // Sample at Q1, service two Q1s later: fixed 3 cycles whatever the opcode
    always @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sampled_r    <= 1'b0;
            take_cnt_r   <= 2'd0;
            irq_take_o   <= 1'b0;
            stack_push_o <= 1'b0;
            pc_load_o    <= 1'b0;
            return_pc_o  <= {`PC_W{1'b0}};
            vector_pc_o  <= `IRQ_VECTOR;
        end
        else
        begin
            irq_take_o   <= 1'b0;
            stack_push_o <= 1'b0;
            pc_load_o    <= 1'b0;
            if (warm_reset_i | brownout_reset_i | ~pending)
            begin
                // Request dropped by a cleared enable stays flagged and returns with it; warm and brown-out reset clear all flags but the port flag
                sampled_r  <= 1'b0;
                take_cnt_r <= 2'd0;
            end
            else if (q1_en && !sampled_r)
            begin
                sampled_r  <= 1'b1;
                take_cnt_r <= TAKE_RELOAD[1:0];
            end
            else if (q1_en && sampled_r)
            begin
                if (take_cnt_r == 2'd1)
                begin
                    irq_take_o   <= 1'b1;
                    stack_push_o <= 1'b1;
                    pc_load_o    <= 1'b1;
                    return_pc_o  <= pc_i;
                    vector_pc_o  <= `IRQ_VECTOR;
                    sampled_r    <= 1'b0;
                    take_cnt_r   <= 2'd0;
                end
                else
                    take_cnt_r <= take_cnt_r - 2'd1;
            end
        end
    end

endmodule // mcu_interrupt_controller
